// ### rtl/beac_pkg.sv
// Constants shared by the byte nonvolatile access controller.
// Assumes a 125 MHz system clock and a CPU data-memory access port.
package beac_pkg;
  localparam int BEAC_AW = 6;
  localparam int BEAC_DW = 8;
  localparam int BEAC_DEPTH = 64;
  // Bank 0 locations
  localparam logic [7:0] BEAC_OFS_BANKSEL = 8'h04;
  localparam logic [7:0] BEAC_OFS_IRQCTL = 8'h0e;
  localparam logic [7:0] BEAC_OFS_POINTER = 8'h1a;
  localparam logic [7:0] BEAC_OFS_BUFFER = 8'h1b;
  // Bank 1 location
  localparam logic [7:0] BEAC_OFS_CONTROL = 8'h40;
  // Control bit positions
  localparam int BEAC_FETCH_TRIG = 0;
  localparam int BEAC_FETCH_PERMIT = 1;
  localparam int BEAC_STORE_TRIG = 2;
  localparam int BEAC_STORE_PERMIT = 3;
  // Interrupt control bit positions
  localparam int BEAC_IRQ_GMASK = 0;
  localparam int BEAC_IRQ_EN = 1;
  localparam int BEAC_IRQ_FLAG = 2;
  localparam logic [7:0] BEAC_RST_BYTE = 8'h00;
  localparam logic [3:0] BEAC_RST_CTL = 4'h0;
  // Timing
  localparam int BEAC_SYS_CLK_HZ = 125000000;
  localparam int BEAC_SLOW_CLK_HZ = 32000;
  localparam int BEAC_SLOW_DIV = BEAC_SYS_CLK_HZ / BEAC_SLOW_CLK_HZ;
  localparam int BEAC_WRITE_TICKS = 64;
  localparam int BEAC_READ_CYCLES = 4;
  typedef enum logic [1:0] {
    BEAC_IDLE = 2'b00,
    BEAC_READ = 2'b01,
    BEAC_WRITE = 2'b10
  } beac_state_e;
endpackage

// ### rtl/beac_mem.sv
// Byte array of the nonvolatile store, one port whose single address serves both write and read.
// Assumes the address is held steady while a read is in progress.
`timescale 1ns/1ps
module beac_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // Clock
  input wire logic i_clk,
  // Access
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule

// ### rtl/beac_wtimer.sv
// Write-cycle timer driven by a free-running slow tick.
// The tick phase is independent of when a write starts, as with a real slow oscillator.
`timescale 1ns/1ps
module beac_wtimer
  import beac_pkg::*;
#(
  parameter int DIV = BEAC_SLOW_DIV,
  parameter int TICKS = BEAC_WRITE_TICKS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  logic [$clog2(DIV)-1:0] div_q;
  logic [$clog2(TICKS+1)-1:0] cnt_q;
  logic tick;

  assign tick = (div_q == '0);

  always_ff @(posedge i_clk) begin
    if (i_srst || tick) begin
      div_q <= ($clog2(DIV))'(DIV - 1);
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      o_busy <= 1'b0;
      cnt_q <= '0;
    end else if (i_start) begin
      o_busy <= 1'b1;
      cnt_q <= ($clog2(TICKS+1))'(TICKS);
    end else if (o_busy && tick) begin
      if (cnt_q == 1) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ### rtl/beac_top.sv
// Byte nonvolatile access controller: registers, sequencing and done interrupt.
// Assumes a CPU data-memory port: one access per cycle, indirect flag from the core.
`timescale 1ns/1ps
module beac_top
  import beac_pkg::*;
#(
  parameter int WRITE_TICKS = BEAC_WRITE_TICKS,
  parameter int SLOW_DIV = BEAC_SLOW_DIV,
  parameter int READ_CYCLES = BEAC_READ_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Data memory access
  input wire logic i_acc_wr,
  input wire logic i_acc_rd,
  input wire logic i_acc_indirect,
  input wire logic [7:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  output logic [7:0] o_acc_rdata,
  // Interrupt hookup
  input wire logic i_stack_full,
  input wire logic i_irq_ack,
  output logic o_irq_req,
  output logic o_write_busy
);
  beac_state_e state_q;
  logic [3:0] ctl_q;
  logic bank_sel_q;
  logic [BEAC_AW-1:0] pointer_q;
  logic [7:0] buffer_q;
  logic [2:0] irqctl_q;
  logic [$clog2(READ_CYCLES+1)-1:0] rcnt_q;
  logic [7:0] mem_q;
  logic wt_busy;
  logic wt_done;
  logic start_wr;
  logic read_end;
  logic bank1;
  logic sel_ctl;
  logic sel_ptr;
  logic sel_buf;
  logic sel_bank;
  logic sel_irq;
  logic ctl_wr;
  logic [7:0] rd_mux;

  assign bank1 = i_acc_indirect && bank_sel_q;
  assign sel_ctl = bank1 && (i_acc_addr == BEAC_OFS_CONTROL);
  assign sel_ptr = !bank1 && (i_acc_addr == BEAC_OFS_POINTER);
  assign sel_buf = !bank1 && (i_acc_addr == BEAC_OFS_BUFFER);
  assign sel_bank = !bank1 && (i_acc_addr == BEAC_OFS_BANKSEL);
  assign sel_irq = !bank1 && (i_acc_addr == BEAC_OFS_IRQCTL);
  assign ctl_wr = i_acc_wr && sel_ctl;
  assign start_wr = (state_q == BEAC_IDLE) && ctl_q[BEAC_STORE_TRIG];
  assign read_end = (state_q == BEAC_READ) && (rcnt_q == 1);

  beac_mem #(
    .AW(BEAC_AW),
    .DW(BEAC_DW)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(start_wr),
    .i_addr(pointer_q),
    .i_wdata(buffer_q),
    .o_rdata(mem_q)
  );

  beac_wtimer #(
    .DIV(SLOW_DIV),
    .TICKS(WRITE_TICKS)
  ) u_wtimer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(start_wr),
    .o_busy(wt_busy),
    .o_done(wt_done)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bank_sel_q <= 1'b0;
    end else if (i_acc_wr && sel_bank) begin
      bank_sel_q <= i_acc_wdata[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pointer_q <= BEAC_RST_BYTE[BEAC_AW-1:0];
    end else if (i_acc_wr && sel_ptr) begin
      pointer_q <= i_acc_wdata[BEAC_AW-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      buffer_q <= BEAC_RST_BYTE;
    end else if (read_end) begin
      buffer_q <= mem_q;
    end else if (i_acc_wr && sel_buf) begin
      buffer_q <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl_q <= BEAC_RST_CTL;
    end else begin
      if (ctl_wr) begin
        ctl_q[BEAC_STORE_PERMIT] <= i_acc_wdata[BEAC_STORE_PERMIT];
        ctl_q[BEAC_FETCH_PERMIT] <= i_acc_wdata[BEAC_FETCH_PERMIT];
        if (i_acc_wdata[BEAC_STORE_TRIG] && ctl_q[BEAC_STORE_PERMIT]
            && !ctl_q[BEAC_FETCH_TRIG]) begin
          ctl_q[BEAC_STORE_TRIG] <= 1'b1;
        end
        if (i_acc_wdata[BEAC_FETCH_TRIG] && ctl_q[BEAC_FETCH_PERMIT]
            && !i_acc_wdata[BEAC_STORE_TRIG] && !ctl_q[BEAC_STORE_TRIG]) begin
          ctl_q[BEAC_FETCH_TRIG] <= 1'b1;
        end
      end
      if (wt_done) begin
        ctl_q[BEAC_STORE_TRIG] <= 1'b0;
      end
      if (read_end) begin
        ctl_q[BEAC_FETCH_TRIG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= BEAC_IDLE;
      rcnt_q <= '0;
    end else begin
      unique case (state_q)
        BEAC_IDLE: begin
          if (start_wr) begin
            state_q <= BEAC_WRITE;
          end else if (ctl_q[BEAC_FETCH_TRIG]) begin
            state_q <= BEAC_READ;
            rcnt_q <= ($clog2(READ_CYCLES+1))'(READ_CYCLES);
          end
        end
        BEAC_READ: begin
          rcnt_q <= rcnt_q - 1'b1;
          if (read_end) begin
            state_q <= BEAC_IDLE;
          end
        end
        BEAC_WRITE: begin
          if (wt_done) begin
            state_q <= BEAC_IDLE;
          end
        end
        default: begin
          state_q <= BEAC_IDLE;
        end
      endcase
    end
  end

  // done flag, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irqctl_q <= 3'h0;
    end else begin
      if (i_acc_wr && sel_irq) begin
        irqctl_q <= i_acc_wdata[2:0];
      end
      if (i_irq_ack) begin
        irqctl_q[BEAC_IRQ_FLAG] <= 1'b0;
      end
      if (wt_done) begin
        irqctl_q[BEAC_IRQ_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq_req <= 1'b0;
      o_write_busy <= 1'b0;
    end else begin
      o_irq_req <= irqctl_q[BEAC_IRQ_FLAG] && irqctl_q[BEAC_IRQ_EN]
                   && irqctl_q[BEAC_IRQ_GMASK] && !i_stack_full && !i_irq_ack;
      o_write_busy <= wt_busy || start_wr;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (sel_ctl) begin
      rd_mux = {4'h0, ctl_q};
    end else if (sel_ptr) begin
      rd_mux = {{(8-BEAC_AW){1'b0}}, pointer_q};
    end else if (sel_buf) begin
      rd_mux = buffer_q;
    end else if (sel_bank) begin
      rd_mux = {7'h00, bank_sel_q};
    end else if (sel_irq) begin
      rd_mux = {5'h00, irqctl_q};
    end
  end

  // Unmapped locations read zero so the core's own registers can be muxed over it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_acc_rdata <= 8'h00;
    end else if (i_acc_rd) begin
      o_acc_rdata <= rd_mux;
    end
  end

  ptr_upper_zero_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_acc_rd && sel_ptr) |=> (o_acc_rdata[7:6] == 2'b00))
    else $error("pointer upper bits not zero");

  store_refused_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (ctl_wr && !ctl_q[BEAC_STORE_PERMIT] && !ctl_q[BEAC_STORE_TRIG])
      |=> !ctl_q[BEAC_STORE_TRIG])
    else $error("write started without permit");

  store_clear_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $fell(ctl_q[BEAC_STORE_TRIG]) |-> $past(wt_done))
    else $error("store trigger cleared before write end");

  fetch_refused_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (ctl_wr && !ctl_q[BEAC_FETCH_PERMIT] && !ctl_q[BEAC_FETCH_TRIG])
      |=> !ctl_q[BEAC_FETCH_TRIG])
    else $error("read started without permit");

  fetch_len_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $rose(ctl_q[BEAC_FETCH_TRIG]) |-> ctl_q[BEAC_FETCH_TRIG] [*2] ##[1:8]
      !ctl_q[BEAC_FETCH_TRIG])
    else $error("read length out of range");

  buffer_load_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $fell(ctl_q[BEAC_FETCH_TRIG]) |-> (buffer_q == $past(mem_q)))
    else $error("buffer not loaded with read byte");

  direct_bank0_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_acc_wr && !i_acc_indirect && !ctl_q[BEAC_STORE_TRIG] && !ctl_q[BEAC_FETCH_TRIG])
      |=> $stable(ctl_q))
    else $error("direct access reached control");

  done_flag_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    wt_done |=> irqctl_q[BEAC_IRQ_FLAG])
    else $error("done flag not set");

  irq_gate_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    o_irq_req |-> $past(irqctl_q[BEAC_IRQ_EN] && irqctl_q[BEAC_IRQ_GMASK] && !i_stack_full))
    else $error("interrupt raised while gated");

  wr_busy_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    start_wr |=> wt_busy && o_write_busy)
    else $error("write timer not running");

  // Reset itself is checked, so this one has no disable clause
  reset_clear_a: assert property (
    @(posedge i_clk)
    i_srst |=> (ctl_q == BEAC_RST_CTL) && !bank_sel_q)
    else $error("reset left control or bank set");

  fetch_clear_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $fell(ctl_q[BEAC_FETCH_TRIG]) |-> $past(read_end))
    else $error("fetch trigger cleared before read end");

  buffer_hold_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    ((state_q == BEAC_READ) && !read_end && !(i_acc_wr && sel_buf)) |=> $stable(buffer_q))
    else $error("buffer changed during read");

  ack_clear_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_irq_ack && !wt_done && !(i_acc_wr && sel_irq)) |=> !irqctl_q[BEAC_IRQ_FLAG])
    else $error("service did not clear done flag");

  read_done_c: cover property (@(posedge i_clk) disable iff (i_srst) read_end);
  write_done_c: cover property (@(posedge i_clk) disable iff (i_srst) wt_done);
  irq_req_c: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_irq_req));
  store_drop_c: cover property (@(posedge i_clk) disable iff (i_srst)
    ctl_wr && i_acc_wdata[BEAC_STORE_TRIG] && !ctl_q[BEAC_STORE_PERMIT]);
  stack_hold_c: cover property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_irq_req) && i_stack_full);
endmodule

// ### sim/tb.sv
// Self-checking bench for the byte nonvolatile access controller.
// Assumes the top module's CPU data-memory port, shortened write timing and an eight-cycle read.
`timescale 1ns/1ps
module tb;
  import beac_pkg::*;
  typedef struct {
    logic ind;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } beac_row_s;
  logic i_clk;
  logic i_srst;
  logic i_acc_wr;
  logic i_acc_rd;
  logic i_acc_indirect;
  logic [7:0] i_acc_addr;
  logic [7:0] i_acc_wdata;
  logic [7:0] o_acc_rdata;
  logic i_stack_full;
  logic i_irq_ack;
  logic o_irq_req;
  logic o_write_busy;
  int n_mismatch;
  int n_compared;
  beac_row_s rows [9];

  beac_top #(.WRITE_TICKS(2), .SLOW_DIV(4), .READ_CYCLES(8)) dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_acc_wr(i_acc_wr),
    .i_acc_rd(i_acc_rd),
    .i_acc_indirect(i_acc_indirect),
    .i_acc_addr(i_acc_addr),
    .i_acc_wdata(i_acc_wdata),
    .o_acc_rdata(o_acc_rdata),
    .i_stack_full(i_stack_full),
    .i_irq_ack(i_irq_ack),
    .o_irq_req(o_irq_req),
    .o_write_busy(o_write_busy)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One strobe cycle, then a released cycle, so calls never collide
  task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_acc_wr <= 1'b1;
    i_acc_indirect <= ind;
    i_acc_addr <= a;
    i_acc_wdata <= v;
    @(posedge i_clk);
    i_acc_wr <= 1'b0;
  endtask

  task automatic rd(input logic ind, input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_acc_rd <= 1'b1;
    i_acc_indirect <= ind;
    i_acc_addr <= a;
    @(posedge i_clk);
    i_acc_rd <= 1'b0;
    #1 v = o_acc_rdata;
  endtask

  task automatic rdc(input logic ind, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(ind, a, v);
    check(v, exp);
  endtask

  // Bounded poll of control until the masked trigger clears
  task automatic poll(input logic [7:0] m);
    logic [7:0] v;
    int k;
    for (k = 0; k < 200; k++) begin
      rd(1'b1, BEAC_OFS_CONTROL, v);
      if ((v & m) === 8'h00) break;
    end
    if (k == 200) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, v & m, 8'h00);
    end
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
  endtask

  task automatic chk_reset();
    #1 check({6'h00, o_irq_req, o_write_busy}, 8'h00);
    rdc(1'b0, BEAC_OFS_BANKSEL, 8'h00);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h00);
    rdc(1'b0, BEAC_OFS_POINTER, 8'h00);
    rdc(1'b0, BEAC_OFS_BUFFER, 8'h00);
    rdc(1'b0, BEAC_OFS_IRQCTL, 8'h00);
    wr(1'b0, BEAC_OFS_BANKSEL, 8'h01);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h00);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs under two hundred cycles
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    i_srst = 1'b1;
    i_acc_wr = 1'b0;
    i_acc_rd = 1'b0;
    i_acc_indirect = 1'b0;
    i_acc_addr = 8'h00;
    i_acc_wdata = 8'h00;
    i_stack_full = 1'b0;
    i_irq_ack = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    rows = '{'{1'b0, 8'h1a, 8'hff, 8'h3f}, '{1'b0, 8'h1b, 8'ha5, 8'ha5},
             '{1'b0, 8'h04, 8'hff, 8'h01}, '{1'b0, 8'h0e, 8'h06, 8'h06},
             '{1'b0, 8'h0e, 8'h00, 8'h00}, '{1'b0, 8'h40, 8'hff, 8'h00},
             '{1'b0, 8'h55, 8'h77, 8'h00}, '{1'b1, 8'h40, 8'hfa, 8'h0a},
             '{1'b1, 8'h40, 8'h00, 8'h00}};
    do_reset();
    chk_reset();
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].ind, rows[i].addr, rows[i].wdata);
      rdc(rows[i].ind, rows[i].addr, rows[i].exp);
    end
    $display("test registers done");
    // Triggers without permit must be dropped
    wr(1'b1, BEAC_OFS_CONTROL, 8'h01);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h00);
    wr(1'b1, BEAC_OFS_CONTROL, 8'h04);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h00);
    check({7'h00, o_write_busy}, 8'h00);
    // Permit written with the trigger does not count yet
    wr(1'b1, BEAC_OFS_CONTROL, 8'h0c);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h08);
    check({7'h00, o_write_busy}, 8'h00);
    $display("test refusal done");
    wr(1'b0, BEAC_OFS_POINTER, 8'h3f);
    wr(1'b0, BEAC_OFS_BUFFER, 8'h5a);
    wr(1'b1, BEAC_OFS_CONTROL, 8'h08);
    wr(1'b1, BEAC_OFS_CONTROL, 8'h0c);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h0c);
    check({7'h00, o_write_busy}, 8'h01);
    poll(8'h04);
    rdc(1'b0, BEAC_OFS_IRQCTL, 8'h04);
    check({7'h00, o_write_busy}, 8'h00);
    check({7'h00, o_irq_req}, 8'h00);
    $display("test write done");
    wr(1'b0, BEAC_OFS_IRQCTL, 8'h06);
    repeat (2) @(posedge i_clk);
    #1 check({7'h00, o_irq_req}, 8'h00);
    wr(1'b0, BEAC_OFS_IRQCTL, 8'h07);
    repeat (2) @(posedge i_clk);
    #1 check({7'h00, o_irq_req}, 8'h01);
    @(posedge i_clk);
    i_stack_full <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 check({7'h00, o_irq_req}, 8'h00);
    @(posedge i_clk);
    i_stack_full <= 1'b0;
    i_irq_ack <= 1'b1;
    @(posedge i_clk);
    i_irq_ack <= 1'b0;
    rdc(1'b0, BEAC_OFS_IRQCTL, 8'h03);
    check({7'h00, o_irq_req}, 8'h00);
    $display("test interrupt done");
    // Buffer is overwritten first so the old byte is told apart from the fetched one
    wr(1'b0, BEAC_OFS_BUFFER, 8'h11);
    wr(1'b1, BEAC_OFS_CONTROL, 8'h02);
    wr(1'b1, BEAC_OFS_CONTROL, 8'h03);
    rdc(1'b1, BEAC_OFS_CONTROL, 8'h03);
    rdc(1'b0, BEAC_OFS_BUFFER, 8'h11);
    poll(8'h01);
    rdc(1'b0, BEAC_OFS_BUFFER, 8'h5a);
    rdc(1'b0, BEAC_OFS_BUFFER, 8'h5a);
    rdc(1'b0, BEAC_OFS_POINTER, 8'h3f);
    $display("test read done");
    wr(1'b1, BEAC_OFS_CONTROL, 8'h0a);
    do_reset();
    chk_reset();
    $display("test second reset done");
    stop_test();
  end
endmodule
